// *** pattern_loop_repeat_sequencer_test.sv ***
// self-checking bench for the loop and repeat sequencer
`timescale 1ns/1ps
module pattern_loop_repeat_sequencer_test;
  import plrs_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_start = 0, i_instr_valid = 0, i_use_slot = 0, i_sw_wr = 0;
  logic [3:0] i_slot_sel = 0, i_sw_addr = 0;
  logic [15:0] i_imm_count = 0, i_sw_wdata = 0;
  logic [23:0] i_start_addr = 0, i_jump_target = 0;
  plrs_op_t i_op = PLRS_OP_PLAIN;
  logic [15:0] o_sw_rdata;
  logic [23:0] o_vec_addr;
  logic o_vec_fire, o_running, o_error;
  logic [3:0] o_depth;
  logic [7:0] lf = 8'h4a;
  int errors = 0, check_count = 0, cyc = 0, sl[16], po[64], pi[64], pt[64], pu[64];
  int q[$], rq[$], dq[$];
  always #2.5 i_core_clk = ~i_core_clk;
  plrs_sequencer u_plrs_sequencer (.*);
  ////////////////////////////////////////////////////////////////
  task chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // the whole run needs under a hundred cycles
  always @(posedge i_core_clk) if (++cyc == 3000) begin
    errors++;
    close_out;
  end
  // reference interpreter; set_loop pushes at once, a stack fault halts the run
  task automatic model(int a, int e);
    int n;
    rq = {};
    dq = {};
    while (a != e) begin
      n = pu[a] ? sl[pi[a]] : pi[a];
      q.push_back(a);
      case (po[a])
        1: repeat (n - 1) q.push_back(a);
        2: begin
          if (rq.size() == 8) return;
          rq.push_back(n);
          dq.push_back(0);
        end
        3: begin
          if (rq.size() == 0) return;
          if (dq[$] + 1 < rq[$]) begin
            dq[$] = dq[$] + 1;
            a = pt[a] - 1;
          end else begin
            rq.pop_back();
            dq.pop_back();
          end
        end
        4: begin
          if (rq.size() > 0) begin
            rq.pop_back();
            dq.pop_back();
          end
          a = pt[a] - 1;
        end
      endcase
      a++;
    end
  endtask : model
  task automatic go(int s, int e, logic xe);
    int a;
    model(s, e);
    @(negedge i_core_clk) i_start_addr = 24'(s);
    i_start = 1;
    @(negedge i_core_clk) i_start = 0;
    for (int i = 0; i < 900 && o_running && o_vec_addr !== e; i++) begin
      a = o_vec_addr[5:0];
      i_op = plrs_op_t'(po[a][2:0]);
      i_use_slot = pu[a][0];
      i_slot_sel = pi[a][3:0];
      i_imm_count = pi[a][15:0];
      i_jump_target = pt[a][23:0];
      i_instr_valid = 1;
      #1 if (o_vec_fire && q.size() > 0) chk(o_vec_addr, 24'(q.pop_front()));
      @(negedge i_core_clk);
    end
    i_instr_valid = 0;
    chk(24'(q.size()), 24'h000000);
    chk(24'(o_error), 24'(xe));
    chk(24'(o_depth), 24'(rq.size()));
    $display("test from %0d done", s);
  endtask : go
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task wslot(int a);
    lf = lfsr_next(lf);
    sl[a] = lf % 3 + 1;
    @(negedge i_core_clk) i_sw_wr = 1;
    i_sw_addr = 4'(a);
    i_sw_wdata = 16'(sl[a]);
    @(negedge i_core_clk) i_sw_wr = 0;
    @(negedge i_core_clk) chk(24'(o_sw_rdata), 24'(sl[a]));
  endtask : wslot
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_rst = 0;
    wslot(15);
    wslot(0);
    po[0] = 2; pu[0] = 1; pi[0] = 15;
    po[1] = 1; pu[1] = 1;
    po[2] = 2; pi[2] = 2;
    po[3] = 1; pi[3] = 3;
    po[4] = 3; pt[4] = 3;
    po[5] = 3; pt[5] = 1;
    po[6] = 2; pi[6] = 65535;
    po[8] = 4; pt[8] = 'h800009;
    go(0, 'h800009, 0);
    for (int i = 20; i < 29; i++) begin
      po[i] = 2;
      pi[i] = 1;
    end
    go(20, 40, 1);
    po[40] = 4; pt[40] = 42;
    po[42] = 1; pi[42] = 1;
    po[43] = 3;
    go(40, 63, 1);
    close_out;
  end
endmodule : pattern_loop_repeat_sequencer_test

// *** plrs_pkg.sv ***
// package for the pattern loop and repeat sequencer
package plrs_pkg;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 16;
  localparam int SLOT_W = 4;
  localparam int NUM_SLOTS = 16;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] SLOT_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    PLRS_OP_PLAIN    = 3'h0,
    PLRS_OP_REPEAT   = 3'h1,
    PLRS_OP_SET_LOOP = 3'h2,
    PLRS_OP_END_LOOP = 3'h3,
    PLRS_OP_EXIT     = 3'h4
  } plrs_op_t;

  typedef enum logic [2:0] {
    PLRS_ST_FETCH  = 3'b001,
    PLRS_ST_REPEAT = 3'b010,
    PLRS_ST_HALT   = 3'b100
  } plrs_state_t;
endpackage : plrs_pkg

// *** plrs_sequencer.sv ***
// loop, repeat and exit control for the vector sequencer
// Notes on behaviour
// - repeat immediate runs vector that many times
// - repeat register takes count from slot
// - set_loop runs vector, records immediate count
// - set_loop register count read at execution
// - end_loop vector runs before loop test
// - fewer passes done: branch to loop start
// - count reached: pop stack, fall through
// - stack holds eight levels, own counts
// - nesting depth checked while running
// - exit_loop runs vector, pops, then branches
// - exit target is a full vector address
`timescale 1ns/1ps
module plrs_sequencer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // run control
  input wire logic i_start,
  input wire logic [plrs_pkg::ADDR_W-1:0] i_start_addr,
  // decoded instruction of the vector at o_vec_addr
  input wire logic i_instr_valid,
  input wire plrs_pkg::plrs_op_t i_op,
  input wire logic i_use_slot,
  input wire logic [plrs_pkg::SLOT_W-1:0] i_slot_sel,
  input wire logic [plrs_pkg::CNT_W-1:0] i_imm_count,
  input wire logic [plrs_pkg::ADDR_W-1:0] i_jump_target,
  // software access to value slots
  input wire logic i_sw_wr,
  input wire logic [plrs_pkg::SLOT_W-1:0] i_sw_addr,
  input wire logic [plrs_pkg::CNT_W-1:0] i_sw_wdata,
  output logic [plrs_pkg::CNT_W-1:0] o_sw_rdata,
  // sequencer outputs
  output logic [plrs_pkg::ADDR_W-1:0] o_vec_addr,
  output logic o_vec_fire,
  output logic o_running,
  output logic o_error,
  output logic [plrs_pkg::DEPTH_W-1:0] o_depth
);
  import plrs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // value slots

  logic [CNT_W-1:0] slot_r [NUM_SLOTS];
  logic [CNT_W-1:0] slot_nxt [NUM_SLOTS];
  logic [CNT_W-1:0] rdata_r;
  logic [CNT_W-1:0] rdata_nxt;

  // zero count is not legal; treated as one so a vector always runs once
  function automatic logic [CNT_W-1:0] plrs_count(input logic [CNT_W-1:0] c);
    plrs_count = (c == CNT_RESET) ? CNT_ONE : c;
  endfunction : plrs_count

  logic [CNT_W-1:0] req_count;

  always_comb begin
    req_count = plrs_count(i_use_slot ? slot_r[i_slot_sel] : i_imm_count);
    rdata_nxt = slot_r[i_sw_addr];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      always_comb begin
        slot_nxt[g] = slot_r[g];
        if (i_sw_wr && (i_sw_addr == SLOT_W'(g))) begin
          slot_nxt[g] = i_sw_wdata;
        end
      end
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          slot_r[g] <= SLOT_RESET;
        end else begin
          slot_r[g] <= slot_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_r <= SLOT_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_sw_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer and loop stack

  logic [CNT_W-1:0] req_r [STACK_DEPTH];
  logic [CNT_W-1:0] req_nxt [STACK_DEPTH];
  logic [CNT_W-1:0] done_r [STACK_DEPTH];
  logic [CNT_W-1:0] done_nxt [STACK_DEPTH];
  logic [DEPTH_W-1:0] depth_r;
  logic [DEPTH_W-1:0] depth_nxt;
  logic [CNT_W-1:0] rep_r;
  logic [CNT_W-1:0] rep_nxt;
  logic [ADDR_W-1:0] pc_r;
  logic [ADDR_W-1:0] pc_nxt;
  logic err_r;
  logic err_nxt;
  plrs_state_t st_r;
  plrs_state_t st_nxt;
  logic [2:0] top;
  logic [2:0] push_lvl;
  logic take;
  logic stack_empty;
  logic stack_full;
  logic do_repeat;
  logic do_push;
  logic do_pop;
  logic do_again;
  logic do_branch;
  logic fault;

  // an instruction counts only in fetch; repeat cycles replay the held vector
  always_comb begin
    take = (st_r == PLRS_ST_FETCH) && i_instr_valid && !i_start;
    stack_empty = (depth_r == DEPTH_RESET);
    stack_full = (depth_r == DEPTH_W'(STACK_DEPTH));
    top = 3'(depth_r - 4'h1);
    push_lvl = depth_r[2:0];
    do_repeat = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    do_again = 1'b0;
    do_branch = 1'b0;
    fault = 1'b0;
    if (take) begin
      unique case (i_op)
        PLRS_OP_PLAIN: begin
        end
        PLRS_OP_REPEAT: begin
          do_repeat = (req_count != CNT_ONE);
        end
        PLRS_OP_SET_LOOP: begin
          // push at once, so a one-vector loop body sees its own level
          fault = stack_full;
          do_push = !stack_full;
        end
        PLRS_OP_END_LOOP: begin
          // the vector has already fired this cycle; decide after it
          fault = stack_empty;
          do_again = !stack_empty && ((done_r[top] + CNT_ONE) < req_r[top]);
          do_pop = !stack_empty && !do_again;
          do_branch = do_again;
        end
        PLRS_OP_EXIT: begin
          // an exit outside any loop still branches but has nothing to pop
          do_pop = !stack_empty;
          do_branch = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // loop stack levels

  genvar k;
  generate
    for (k = 0; k < STACK_DEPTH; k++) begin : g_level
      always_comb begin
        req_nxt[k] = req_r[k];
        done_nxt[k] = done_r[k];
        if (do_push && (push_lvl == 3'(k))) begin
          req_nxt[k] = req_count;
          done_nxt[k] = CNT_RESET;
        end else if (do_again && (top == 3'(k))) begin
          done_nxt[k] = done_r[k] + CNT_ONE;
        end
      end
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          req_r[k] <= CNT_RESET;
          done_r[k] <= CNT_RESET;
        end else begin
          req_r[k] <= req_nxt[k];
          done_r[k] <= done_nxt[k];
        end
      end
    end
  endgenerate

  always_comb begin
    depth_nxt = depth_r;
    if (i_start) begin
      depth_nxt = DEPTH_RESET;
    end else if (do_push) begin
      depth_nxt = depth_r + 4'h1;
    end else if (do_pop) begin
      depth_nxt = depth_r - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      depth_r <= DEPTH_RESET;
    end else begin
      depth_r <= depth_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vector flow

  always_comb begin
    rep_nxt = rep_r;
    st_nxt = st_r;
    if (i_start) begin
      st_nxt = PLRS_ST_FETCH;
    end else begin
      unique case (st_r)
        PLRS_ST_FETCH: begin
          if (fault) begin
            st_nxt = PLRS_ST_HALT;
          end else if (do_repeat) begin
            rep_nxt = req_count - CNT_ONE;
            st_nxt = PLRS_ST_REPEAT;
          end
        end
        PLRS_ST_REPEAT: begin
          rep_nxt = rep_r - CNT_ONE;
          if (rep_r == CNT_ONE) begin
            st_nxt = PLRS_ST_FETCH;
          end
        end
        PLRS_ST_HALT: begin
        end
        default: begin
          st_nxt = PLRS_ST_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rep_r <= CNT_RESET;
      st_r <= PLRS_ST_HALT;
    end else begin
      rep_r <= rep_nxt;
      st_r <= st_nxt;
    end
  end

  // a fault still steps the pc; the halt keeps that address from running
  always_comb begin
    pc_nxt = pc_r;
    if (i_start) begin
      pc_nxt = i_start_addr;
    end else if (take) begin
      if (do_branch) begin
        pc_nxt = i_jump_target;
      end else if (!do_repeat) begin
        pc_nxt = pc_r + ADDR_W'(1);
      end
    end else if ((st_r == PLRS_ST_REPEAT) && (rep_r == CNT_ONE)) begin
      pc_nxt = pc_r + ADDR_W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pc_r <= ADDR_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // sticky until the next start, so software can read why the run stopped
  always_comb begin
    err_nxt = err_r;
    if (i_start) begin
      err_nxt = 1'b0;
    end else if (fault) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_vec_addr = pc_r;
  assign o_vec_fire = take || (st_r == PLRS_ST_REPEAT);
  assign o_running = (st_r != PLRS_ST_HALT);
  assign o_error = err_r;
  assign o_depth = depth_r;
endmodule : plrs_sequencer

// *** plrs_sequencer_chk.sv ***
// port checker for the loop and repeat sequencer
`timescale 1ns/1ps
module plrs_sequencer_chk
  import plrs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire plrs_op_t i_op,
  input wire logic i_use_slot,
  input wire logic [CNT_W-1:0] i_imm_count,
  input wire logic [ADDR_W-1:0] i_jump_target,
  input wire logic [ADDR_W-1:0] o_vec_addr,
  input wire logic o_vec_fire,
  input wire logic o_running,
  input wire logic o_error,
  input wire logic [DEPTH_W-1:0] o_depth
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // only the first cycle of a repeat may open a check
  logic rep_r;
  always_ff @(posedge i_core_clk) rep_r <= o_vec_fire && i_op == PLRS_OP_REPEAT;
  ////////////////////////////////////////////////////////////////
  AST_REP3: assert property (o_vec_fire && i_op == PLRS_OP_REPEAT && !rep_r
    && !i_use_slot && i_imm_count == 16'h0003 |=> (o_vec_fire && $stable(o_vec_addr))[*2]
    ##1 o_vec_addr == $past(o_vec_addr, 3) + 24'h000001) else $error("repeat");
  AST_ENDL: assert property (o_vec_fire && i_op == PLRS_OP_END_LOOP && o_depth != 4'h0
    |=> o_vec_addr == $past(i_jump_target) && $stable(o_depth) || o_vec_addr ==
    $past(o_vec_addr) + 24'h000001 && o_depth == $past(o_depth) - 4'h1) else $error("end");
  AST_EXIT: assert property (o_vec_fire && i_op == PLRS_OP_EXIT && o_depth != 4'h0
    |=> o_vec_addr == $past(i_jump_target) && o_depth == $past(o_depth) - 4'h1) else $error("exit");
  AST_STEP: assert property (o_vec_fire && i_op == PLRS_OP_PLAIN
    |=> o_error || o_vec_addr == $past(o_vec_addr) + 24'h000001) else $error("step");
  AST_DMAX: assert property (o_depth <= 4'h8) else $error("depth");
  AST_PUSH: assert property (i_op == PLRS_OP_SET_LOOP && o_depth != 4'h8
    && o_vec_fire |=> o_depth == $past(o_depth) + 4'h1) else $error("push");
  AST_FULL: assert property (i_op == PLRS_OP_SET_LOOP && o_depth == 4'h8
    && o_vec_fire |=> o_error && !o_running && $stable(o_depth)) else $error("full");
  AST_HALT: assert property (o_error |-> !o_running && !o_vec_fire) else $error("halt");
  AST_GO: assert property (i_start |=> o_running && !o_error && o_depth == 4'h0)
    else $error("start");
  AST_OVF: assert property ($rose(o_error) |-> o_depth == 4'h8 || o_depth == 4'h0)
    else $error("overflow");
endmodule : plrs_sequencer_chk

bind plrs_sequencer plrs_sequencer_chk u_plrs_sequencer_chk (.i_core_clk, .i_rst, .i_start,
  .i_op, .i_use_slot, .i_imm_count, .i_jump_target, .o_vec_addr, .o_vec_fire, .o_running,
  .o_error, .o_depth);
